// ---- include/bcs_pkg.sv ----
// constants and types shared by the battery charge sequencer
package bcs_pkg;
    // timing base
    localparam int CLK_NS              = 20;
    localparam int TICK_US             = 100;
    localparam int TICK_CYCLES         = TICK_US * 1000 / CLK_NS;
    localparam int HOUR_MS             = 3_600_000;
    localparam int HOUR_TICKS          = HOUR_MS * (1000 / TICK_US);
    localparam int TRICKLE_LIMIT_MIN   = 30;
    localparam int TRICKLE_TICKS       = TRICKLE_LIMIT_MIN * (HOUR_TICKS / 60);
    localparam int DEBOUNCE_US         = 2500;
    localparam int DEBOUNCE_TICKS      = DEBOUNCE_US / TICK_US;
    localparam int SAMPLE_PERIOD_MS    = 150;
    localparam int SAMPLE_PERIOD_TICKS = SAMPLE_PERIOD_MS * 1000 / TICK_US;
    localparam int SAMPLE_WINDOW_US    = 150;
    localparam int SAMPLE_WINDOW_TICKS = (SAMPLE_WINDOW_US + TICK_US - 1) / TICK_US;

    // register map (byte addresses)
    localparam logic [3:0] CTRL_ADDR   = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam int         CTRL_W      = 11;
    localparam int         STATUS_W    = 7;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // thermistor status codes
    localparam logic [1:0] THERM_OK   = 2'h0;
    localparam logic [1:0] THERM_HOT  = 2'h1;
    localparam logic [1:0] THERM_COLD = 2'h2;
    localparam logic [1:0] THERM_CRIT = 2'h3;

    typedef enum logic [2:0] {
        ST_PRECHARGE,
        ST_CONST_CURRENT,
        ST_CONST_VOLTAGE,
        ST_TERMINATED,
        ST_PAUSED,
        ST_BAD_BATTERY,
        ST_DISABLED
    } bcs_state_type;

    // control register fields, msb first
    typedef struct packed {
        logic       cond_enable;
        logic       charge_disable;
        logic [2:0] timer_hours_m1;
        logic [1:0] cx_select;
        logic       float_select;
        logic [2:0] charge_level;
    } bcs_ctrl_type;

    localparam bcs_ctrl_type CTRL_RESET = 11'h0C0;

    // status register fields, msb first
    typedef struct packed {
        logic       cond_load;
        logic [1:0] therm_code;
        logic       full_capacity;
        logic [2:0] state;
    } bcs_status_type;

    // analog comparator outputs
    typedef struct packed {
        logic below_trickle;
        logic at_float;
        logic below_recharge;
        logic full_capacity;
        logic batt_at_cond_floor;
        logic temp_hot;
        logic temp_cold;
        logic temp_crit_hot;
        logic temp_below_release;
        logic temp_below_cond_off;
    } bcs_comp_type;

    // latched thermistor sample
    typedef struct packed {
        logic hot;
        logic cold;
        logic crit_hot;
        logic below_release;
        logic below_cond_off;
    } bcs_therm_type;
endpackage

// ---- src/bcs_top.sv ----
// battery charge sequencer with axi4-lite register port
//
// Behaviour
// - below trickle threshold at cycle start, charge at one fifth current (trickle mode)
// - trickle lasting over half an hour terminates into bad battery status
// - above trickle threshold, move to full constant-current phase
// - three-bit level selects servo 500mV to 1.2V in 100mV steps, reset 500mV
// - float select picks 4.100V or 4.200V, default 4.100V
// - two-bit full-capacity threshold select; comparator result readable as status
// - safety timer starts when battery reaches float voltage
// - timer expiry stops charging and enters terminated state
// - safety timer one to eight hours in hour steps, default four
// - terminated stays off, recharges when battery drops below recharge threshold
// - running timer resets to zero when battery drops below recharge threshold
// - below-recharge condition must persist over 2.5ms before acting
// - supply lockout cycling or brief register disable restarts cycle and timer
// - pause charging while hot or cold comparator says out of range
// - in constant-voltage phase, freeze timer while temperature invalid
// - critically hot thermistor reported as its own status code
// - thermistor sensed continuously when enabled, short window every 150ms otherwise
// - thermistor status updated every tick when enabled, otherwise only at end of each sample window
// - conditioner load on when enabled and critical hot; off at 3.9V or 58C
// - after hot pause resume only below the lower release temperature
// - conditioner works regardless of power, termination or register disable
`timescale 1ns/100ps
module bcs_top
#(
    parameter int TICK_CYCLES_P   = bcs_pkg::TICK_CYCLES,
    parameter int HOUR_TICKS_P    = bcs_pkg::HOUR_TICKS,
    parameter int TRICKLE_TICKS_P = bcs_pkg::TRICKLE_TICKS
)
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write
    input  wire logic [3:0]           awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    // axi4-lite read
    input  wire logic [3:0]           araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    // analog side
    input  wire bcs_pkg::bcs_comp_type comp_in,
    input  wire logic                 input_undervoltage_lockout,
    output logic                      charge_on,
    output logic                      trickle_mode,
    output logic [2:0]                charge_servo_level,
    output logic                      float_select,
    output logic [1:0]                cx_select,
    output logic                      thermistor_sample,
    output logic                      cond_load_on
);
    import bcs_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES_P + 1);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    bcs_comp_type  comp_meta;
    bcs_comp_type  comp;
    logic          input_undervoltage_lockout_meta;
    logic          input_undervoltage_lockout_ok;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            comp_meta <= '0;
            comp      <= '0;
            input_undervoltage_lockout_meta <= 1'b0;
            input_undervoltage_lockout_ok   <= 1'b0;
        end
        else
        begin
            comp_meta <= comp_in;
            comp      <= comp_meta;
            input_undervoltage_lockout_meta <= input_undervoltage_lockout;
            input_undervoltage_lockout_ok   <= input_undervoltage_lockout_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler tick
    logic [TW-1:0] tick_cnt;
    logic          tick;
    wire           tick_wrap = tick_cnt == TW'(TICK_CYCLES_P - 1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + TW'(1);
            tick     <= tick_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    bcs_ctrl_type   ctrl;
    bcs_state_type  state;
    bcs_state_type  next_state;
    bcs_state_type  ret_state;
    logic [31:0]    timer;
    logic [31:0]    next_timer;
    bcs_therm_type  therm;
    logic           hot_hold;

    wire charge_en = input_undervoltage_lockout_ok && !ctrl.charge_disable;
    wire pause_req = hot_hold || therm.hot || therm.cold;
    wire [31:0] timer_limit = (32'(ctrl.timer_hours_m1) + 32'd1) * 32'(HOUR_TICKS_P);
    wire [1:0] therm_code = therm.crit_hot ? THERM_CRIT :
                            therm.hot      ? THERM_HOT  :
                            therm.cold     ? THERM_COLD : THERM_OK;

    ////////////////////////////////////////////////////////////////////////////
    // recharge debounce
    logic [7:0] rchg_cnt;
    logic       rchg_ok;
    logic       rchg_ok_d;
    wire        rchg_evt = rchg_ok && !rchg_ok_d;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rchg_cnt  <= '0;
            rchg_ok   <= 1'b0;
            rchg_ok_d <= 1'b0;
        end
        else
        begin
            if (!comp.below_recharge)
                rchg_cnt <= '0;
            else if (tick && !rchg_ok)
                rchg_cnt <= rchg_cnt + 8'd1;
            rchg_ok   <= comp.below_recharge && rchg_cnt > 8'(DEBOUNCE_TICKS);
            rchg_ok_d <= rchg_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // thermistor sampling
    logic [10:0] samp_cnt;
    wire         samp_wrap = samp_cnt == 11'(SAMPLE_PERIOD_TICKS - 1);
    wire         in_window = samp_cnt < 11'(SAMPLE_WINDOW_TICKS);
    wire         therm_upd = tick && (charge_en ||
                             samp_cnt == 11'(SAMPLE_WINDOW_TICKS - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            samp_cnt          <= '0;
            therm             <= '0;
            hot_hold          <= 1'b0;
            thermistor_sample <= 1'b0;
        end
        else
        begin
            if (tick)
                samp_cnt <= samp_wrap ? '0 : samp_cnt + 11'd1;
            thermistor_sample <= charge_en || in_window;
            if (therm_upd)
            begin
                therm <= {comp.temp_hot, comp.temp_cold, comp.temp_crit_hot,
                          comp.temp_below_release, comp.temp_below_cond_off};
            end
            if (therm.hot)
                hot_hold <= 1'b1;
            else if (therm.below_release)
                hot_hold <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // charge state machine
    always_comb
    begin
        next_state = state;
        if (!charge_en)
            next_state = ST_DISABLED;
        else
        begin
            unique case (state)
                ST_DISABLED:      next_state = ST_PRECHARGE;
                ST_PRECHARGE:
                    if (pause_req)
                        next_state = ST_PAUSED;
                    else if (timer >= 32'(TRICKLE_TICKS_P))
                        next_state = ST_BAD_BATTERY;
                    else if (!comp.below_trickle)
                        next_state = ST_CONST_CURRENT;
                ST_CONST_CURRENT:
                    if (pause_req)
                        next_state = ST_PAUSED;
                    else if (comp.at_float)
                        next_state = ST_CONST_VOLTAGE;
                ST_CONST_VOLTAGE:
                    if (pause_req)
                        next_state = ST_PAUSED;
                    else if (timer >= timer_limit)
                        next_state = ST_TERMINATED;
                ST_PAUSED:
                    if (!pause_req)
                        next_state = ret_state;
                ST_TERMINATED:
                    if (rchg_ok)
                        next_state = ST_PRECHARGE;
                ST_BAD_BATTERY:   next_state = ST_BAD_BATTERY;
            endcase
        end
    end

    wire pause_edge = state == ST_PAUSED || next_state == ST_PAUSED;

    always_comb
    begin
        next_timer = timer;
        if (state != next_state && !pause_edge)
            next_timer = '0;
        else if (state == ST_CONST_VOLTAGE && rchg_evt)
            next_timer = '0;
        else if (tick && (state == ST_PRECHARGE || state == ST_CONST_VOLTAGE))
            next_timer = timer + 32'd1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state     <= ST_DISABLED;
            ret_state <= ST_PRECHARGE;
            timer     <= '0;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
            if (next_state == ST_PAUSED && state != ST_PAUSED)
                ret_state <= state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conditioner and analog controls
    wire cond_off = comp.batt_at_cond_floor || therm.below_cond_off;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cond_load_on       <= 1'b0;
            charge_on          <= 1'b0;
            trickle_mode       <= 1'b0;
            charge_servo_level <= '0;
            float_select       <= 1'b0;
            cx_select          <= '0;
        end
        else
        begin
            if (!ctrl.cond_enable || cond_off)
                cond_load_on <= 1'b0;
            else if (therm.crit_hot)
                cond_load_on <= 1'b1;
            charge_on <= state == ST_PRECHARGE || state == ST_CONST_CURRENT ||
                         state == ST_CONST_VOLTAGE;
            trickle_mode       <= state == ST_PRECHARGE;
            charge_servo_level <= ctrl.charge_level;
            float_select       <= ctrl.float_select;
            cx_select          <= ctrl.cx_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    logic         aw_full;
    logic         w_full;
    logic [3:0]   wr_addr;
    logic [31:0]  wr_data;
    logic [3:0]   wr_strb;
    bcs_ctrl_type next_ctrl;
    bcs_status_type status;

    wire aw_take     = awvalid && awready;
    wire w_take      = wvalid && wready;
    wire ar_take     = arvalid && arready;
    wire do_write    = aw_full && w_full && !bvalid;
    wire next_aw     = aw_take || (aw_full && !do_write);
    wire next_w      = w_take || (w_full && !do_write);
    wire next_bvalid = do_write || (bvalid && !bready);
    wire next_rvalid = ar_take || (rvalid && !rready);
    wire wr_ctrl     = wr_addr == CTRL_ADDR;
    wire wr_known    = wr_ctrl || wr_addr == STATUS_ADDR;
    wire rd_known    = araddr == CTRL_ADDR || araddr == STATUS_ADDR;

    genvar gi;
    generate
        for (gi = 0; gi < CTRL_W; gi++)
        begin : g_strb
            assign next_ctrl[gi] = wr_strb[gi / 8] ? wr_data[gi] : ctrl[gi];
        end
    endgenerate

    assign status = {cond_load_on, therm_code, comp.full_capacity, state};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl    <= CTRL_RESET;
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end
        else
        begin
            aw_full <= next_aw;
            w_full  <= next_w;
            awready <= !next_aw && !next_bvalid;
            wready  <= !next_w && !next_bvalid;
            bvalid  <= next_bvalid;
            arready <= !next_rvalid;
            rvalid  <= next_rvalid;
            if (aw_take)
                wr_addr <= {awaddr[3:2], 2'b00};
            if (w_take)
            begin
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (do_write)
            begin
                bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
                if (wr_ctrl)
                    ctrl <= next_ctrl;
            end
            if (ar_take)
            begin
                rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
                rdata <= araddr[3:2] == CTRL_ADDR[3:2]   ? {21'h0, ctrl} :
                         araddr[3:2] == STATUS_ADDR[3:2] ? {25'h0, status} : 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_run(bcs_state_type s);
        state == s && charge_en && !pause_req;
    endsequence

    a_precharge_exit: assert property (s_run(ST_PRECHARGE) ##0 !comp.below_trickle
        ##0 timer < 32'(TRICKLE_TICKS_P) |=> state == ST_CONST_CURRENT ##1 !trickle_mode)
        else $error("precharge did not advance");
    a_bad_battery: assert property (s_run(ST_PRECHARGE) ##0
        timer >= 32'(TRICKLE_TICKS_P) |=> state == ST_BAD_BATTERY ##1 !charge_on)
        else $error("trickle timeout missed");
    a_timer_start: assert property (s_run(ST_CONST_CURRENT) ##0 comp.at_float
        |=> state == ST_CONST_VOLTAGE && timer == 32'd0)
        else $error("timer not started at float");
    a_timer_expire: assert property (s_run(ST_CONST_VOLTAGE) ##0
        timer >= timer_limit |=> state == ST_TERMINATED ##1 !charge_on)
        else $error("timer expiry ignored");
    a_timer_freeze: assert property (state == ST_PAUSED && charge_en && pause_req
        |=> $stable(timer))
        else $error("timer moved while paused");
    a_timer_clear: assert property (s_run(ST_CONST_VOLTAGE) ##0 rchg_evt ##0
        timer < timer_limit |=> timer == 32'd0)
        else $error("timer not cleared by recharge");
    a_rchg_qual: assert property (!comp.below_recharge |=> !rchg_ok ##1 !rchg_evt)
        else $error("recharge qualified too early");
    a_recharge: assert property (state == ST_TERMINATED && charge_en && rchg_ok
        |=> state == ST_PRECHARGE ##1 charge_on && trickle_mode)
        else $error("recharge not started");
    a_restart: assert property (!charge_en |=> state == ST_DISABLED ##1 !charge_on)
        else $error("disable not honoured");
    a_therm_hold: assert property (!therm_upd |=> $stable(therm))
        else $error("thermistor status changed off period");
    a_cond_on: assert property (ctrl.cond_enable && therm.crit_hot && !cond_off
        |=> cond_load_on)
        else $error("conditioner failed to engage");
    a_cond_off: assert property (cond_load_on && cond_off |=> !cond_load_on)
        else $error("conditioner failed to release");
    a_write_resp: assert property (do_write |=> bvalid &&
        (!$past(wr_ctrl) || ctrl == $past(next_ctrl)))
        else $error("write response missing");
endmodule

// ---- tb/bcs_host.sv ----
// axi4-lite host model that drives the register port
`timescale 1ns/100ps
module bcs_host
(
    // clock
    input  wire logic        aclk,
    // write channels
    output logic [3:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // read channels
    output logic [3:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // one write, each channel released when taken; x response when no answer came
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, 4'hf, 3'b111};
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid && n < 64);
        r = bvalid ? bresp : 2'bxx;
        bready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // one read; x response when no answer came
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid && n < 64);
        {r, v} = rvalid ? {rresp, rdata} : 34'bx;
        rready <= 1'b0;
    endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the battery charge sequencer
`timescale 1ns/100ps
module tb;
    import bcs_pkg::*;
    logic         aclk, aresetn, input_undervoltage_lockout, charge_on, trickle_mode;
    logic         awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready, float_select, thermistor_sample;
    logic         cond_load_on;
    logic [3:0]   awaddr, araddr, wstrb;
    logic [1:0]   bresp, rresp, cx_select;
    logic [2:0]   charge_servo_level;
    logic [31:0]  wdata, rdata, d;
    bcs_comp_type comp_in;
    int           miscompares, num_checks;
    // ctrl word, then expected level, float select and threshold select
    logic [16:0]  rows [4] = '{17'h0_01f8, 17'h0_0605, 17'h0_0d6b, 17'h0_0a96};
    bcs_top #(.TICK_CYCLES_P(4), .HOUR_TICKS_P(50), .TRICKLE_TICKS_P(20)) uut
    (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .comp_in, .input_undervoltage_lockout, .charge_on, .trickle_mode,
        .charge_servo_level, .float_select, .cx_select, .thermistor_sample, .cond_load_on
    );
    bcs_host h
    (
        .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
    );
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [1:0] r;
        h.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
        if (r === 2'bxx) report_and_stop();
    endtask
    task automatic wrc(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        logic [1:0] r;
        h.wr(a, v, r);
        chk({30'h0, r}, {30'h0, er});
        if (r === 2'bxx) report_and_stop();
    endtask
    // poll the state field until it matches, a bounded number of reads
    task automatic wt(input bcs_state_type s);
        logic [1:0] r;
        int n;
        n = 0;
        do
        begin
            h.rd(STATUS_ADDR, d, r);
            n++;
        end
        while (d[2:0] !== s && n < 80);
        chk({29'h0, d[2:0]}, {29'h0, s});
        if (d[2:0] !== s) report_and_stop();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        report_and_stop();
    end
    initial
    begin
        {aresetn, input_undervoltage_lockout, miscompares, num_checks} = '0;
        comp_in = '0;
        comp_in.temp_below_release = 1'b1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(CTRL_ADDR, 32'h0000_00c0, RESP_OKAY);
        wt(ST_DISABLED);
        rdc(4'h8, 32'h0000_0000, RESP_SLVERR);
        wrc(4'hc, 32'h0000_0fff, RESP_SLVERR);
        foreach (rows[i])
        begin
            wrc(CTRL_ADDR, {21'h0, rows[i][16:6]}, RESP_OKAY);
            repeat (3) @(posedge aclk);
            chk({26'h0, charge_servo_level, float_select, cx_select}, {26'h0, rows[i][5:0]});
        end
        chk({31'h0, thermistor_sample}, 32'h0000_0000);
        comp_in.below_trickle <= 1'b1;
        input_undervoltage_lockout <= 1'b1;
        wt(ST_PRECHARGE);
        repeat (2) @(posedge aclk);
        chk({30'h0, charge_on, trickle_mode}, 32'h0000_0003);
        chk({31'h0, thermistor_sample}, 32'h0000_0001);
        comp_in.below_trickle <= 1'b0;
        wt(ST_CONST_CURRENT);
        comp_in.at_float <= 1'b1;
        wt(ST_CONST_VOLTAGE);
        comp_in.below_recharge <= 1'b1;
        repeat (150) @(posedge aclk);
        comp_in.below_recharge <= 1'b0;
        repeat (80) @(posedge aclk);
        rdc(STATUS_ADDR, 32'h0000_0002, RESP_OKAY);
        wt(ST_TERMINATED);
        repeat (2) @(posedge aclk);
        chk({31'h0, charge_on}, 32'h0000_0000);
        comp_in.at_float <= 1'b0;
        comp_in.below_recharge <= 1'b1;
        repeat (60) @(posedge aclk);
        wt(ST_TERMINATED);
        wt(ST_CONST_CURRENT);
        comp_in.below_recharge <= 1'b0;
        comp_in.temp_hot <= 1'b1;
        comp_in.temp_below_release <= 1'b0;
        comp_in.full_capacity <= 1'b1;
        wt(ST_PAUSED);
        rdc(STATUS_ADDR, 32'h0000_001c, RESP_OKAY);
        wrc(CTRL_ADDR, 32'h0000_0422, RESP_OKAY);
        comp_in.temp_crit_hot <= 1'b1;
        repeat (12) @(posedge aclk);
        rdc(STATUS_ADDR, 32'h0000_007c, RESP_OKAY);
        comp_in.full_capacity <= 1'b0;
        comp_in.temp_below_cond_off <= 1'b1;
        comp_in.temp_crit_hot <= 1'b0;
        comp_in.temp_hot <= 1'b0;
        repeat (12) @(posedge aclk);
        rdc(STATUS_ADDR, 32'h0000_0004, RESP_OKAY);
        comp_in.temp_below_release <= 1'b1;
        wt(ST_CONST_CURRENT);
        comp_in.temp_cold <= 1'b1;
        repeat (12) @(posedge aclk);
        rdc(STATUS_ADDR, 32'h0000_0024, RESP_OKAY);
        comp_in.temp_cold <= 1'b0;
        wrc(CTRL_ADDR, 32'h0000_0222, RESP_OKAY);
        wt(ST_DISABLED);
        comp_in.below_trickle <= 1'b1;
        wrc(CTRL_ADDR, 32'h0000_0022, RESP_OKAY);
        wt(ST_PRECHARGE);
        wt(ST_BAD_BATTERY);
        report_and_stop();
    end
endmodule
